// file: dpb_sram.sv
// Purpose: Dual-port two-word burst SRAM with shared address and DDR ports.
// Assumes: clk is the input clock; each clk edge alternates between the
//   rising in_strobe_p edge (phase 0) and the rising in_strobe_n edge.
// Notes: Read data leaves on out_clk unless single-clock mode is strapped.
//
// Summary of operation
// - Read select at strobe rise latches address.
// - Latency one and half, or one legacy; here two with the pll on, one and half with it off, in single-clock mode.
// - Lowest word first, second word next edge.
// - Release read bus after the last word.
// - Write select at strobe rise captures word0.
// - Strobe_n rise latches address, word1, commits.
// - Deselected write port still finishes pending write.
// - Byte selects sampled with each data word.
// - Single-clock mode strapped at each reset release only.
// - Same-cycle read and write; read sees newest.
// - Selects sampled on strobe_p; ports independent.
// - Recalibrate output impedance every fixed period.
// - Echo clocks follow output or input clocks.
// - PLL locks fixed time after stable clock.
// - Inputs on input clocks, outputs on output.
// - Two internal arrays, one word each.
// - Power-up deselected with read bus released.
// - Burst words go to A and A+1.
// - Byte selects active low; all high writes nothing.
`timescale 1ns/1ns
`default_nettype none
`include "dpb_defines.svh"

module dpb_sram #(
  parameter int DATA_W = `DPB_DATA_W,
  localparam int LANES = DATA_W / `DPB_LANE_W,
  localparam int ADDR_W = (DATA_W == `DPB_DATA_W) ? `DPB_ADDR_W_X18 :
    `DPB_ADDR_W_X36
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic out_clk,
  input wire logic read_port_sel_n,
  input wire logic write_port_sel_n,
  input wire logic [LANES-1:0] byte_lane_sel_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic pll_disable_n,
  input wire logic out_strobe_p,
  input wire logic out_strobe_n,
  input wire logic impedance_ref_pin,
  output logic [DATA_W-1:0] read_bus,
  output logic read_bus_oe,
  output logic echo_out_p,
  output logic echo_out_n,
  output logic single_clock_mode,
  output logic pll_locked,
  output logic impedance_cal_pulse,
  output logic impedance_strong
);

  // Strap and static pins come from outside and are synchronised first.
  logic out_p_s1_reg;
  logic out_p_s2_reg;
  logic out_n_s1_reg;
  logic out_n_s2_reg;
  logic pll_s1_reg;
  logic pll_s2_reg;
  logic zref_s1_reg;
  logic zref_s2_reg;

  // Core sequencing state.
  logic phase_reg;           // Low while the coming edge is a strobe_p rise.
  logic strap_done_reg;      // Strap sampled once after reset release.
  logic single_mode_reg;     // Output registers run on the input clock.
  logic rd_pend_reg;         // A read was latched at the last strobe_p.
  logic [ADDR_W-1:0] rd_addr_reg;
  logic wr_pend_reg;         // A write awaits its second word.
  logic [DATA_W-1:0] wr_word0_reg;
  logic [LANES-1:0] wr_lane0_reg;
  logic rv1_reg;             // Array read data ready.
  logic rv2_reg;             // Same, one cycle later.
  logic rd_tog_reg;          // Flips once per read burst, at its hand-off.
  logic [DATA_W-1:0] slot_w0_reg [2];
  logic [DATA_W-1:0] slot_w1_reg [2];
  logic [`DPB_PLL_LOCK_W-1:0] lock_cnt_reg;
  logic pll_locked_reg;
  logic [`DPB_ZCAL_W-1:0] zcal_cnt_reg;
  logic zcal_pulse_reg;
  logic zstrong_reg;

  // Link-side state on out_clk.
  logic lrst_s1_reg;
  logic lrst_s2_reg;
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic echo_lnk_reg;

  // Decodes in the core domain.
  wire k_rise;
  wire rd_take;
  wire wr_take;
  wire arr_wr_en;
  wire arr_rd_en;
  wire pll_on;
  wire fire;
  wire lnk_ev;
  wire [LANES-1:0] wr_lane1;
  wire [DATA_W-1:0] arr_word0;
  wire [DATA_W-1:0] arr_word1;
  wire [DATA_W-1:0] core_q;
  wire core_oe;
  wire [DATA_W-1:0] lnk_q;
  wire lnk_oe;

  // Selects count only at the strobe_p rise.
  assign k_rise = (phase_reg == 1'b0);
  assign rd_take = k_rise && !read_port_sel_n;
  assign wr_take = k_rise && !write_port_sel_n;
  // The commit needs no select: a pending write always ends.
  assign arr_wr_en = !k_rise && wr_pend_reg;
  // Arrays are read at the next strobe_p rise, after any commit.
  assign arr_rd_en = k_rise && rd_pend_reg;
  // Low byte selects enable their lanes; all high writes nothing.
  assign wr_lane1 = ~byte_lane_sel_n;
  assign pll_on = pll_s2_reg;
  // An extra cycle of delay stands for the extra half cycle of latency.
  assign fire = pll_on ? rv2_reg : rv1_reg;
  assign lnk_ev = tog_s2_reg ^ tog_s3_reg;

  // Synchronisers for the strap and static pins; not reset so the strap
  // is already settled when reset is released.
  always_ff @(posedge clk) begin
    out_p_s1_reg <= out_strobe_p;
    out_p_s2_reg <= out_p_s1_reg;
    out_n_s1_reg <= out_strobe_n;
    out_n_s2_reg <= out_n_s1_reg;
    pll_s1_reg <= pll_disable_n;
    pll_s2_reg <= pll_s1_reg;
    zref_s1_reg <= impedance_ref_pin;
    zref_s2_reg <= zref_s1_reg;
  end

  // Strap capture: taken once, at the first edge after reset release,
  // and never again while running.
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_done_reg <= 1'b0;
      single_mode_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      single_mode_reg <= out_p_s2_reg && out_n_s2_reg;
    end
  end

  // Edge phase: strobe_p and strobe_n rises alternate on clk.
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg <= `DPB_PHASE_RST;
    end else begin
      phase_reg <= !phase_reg;
    end
  end

  // Read port: the address register loads only on a selected strobe_p
  // rise; both ports come up deselected.
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_pend_reg <= `DPB_SEL_RST;
    end else if (k_rise) begin
      rd_pend_reg <= rd_take;
    end
  end

  // Read address register.
  always_ff @(posedge clk) begin
    if (rd_take) begin
      rd_addr_reg <= address;
    end
  end

  // Write port: the first word and its lanes are captured together.
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pend_reg <= `DPB_SEL_RST;
    end else if (k_rise) begin
      wr_pend_reg <= wr_take;
    end
  end

  // Lower write-data register and its lane enables.
  always_ff @(posedge clk) begin
    if (wr_take) begin
      wr_word0_reg <= write_data;
      wr_lane0_reg <= ~byte_lane_sel_n;
    end
  end

  // Read data ready flags that time the hand-off.
  always_ff @(posedge clk) begin
    if (reset) begin
      rv1_reg <= 1'b0;
      rv2_reg <= 1'b0;
    end else begin
      rv1_reg <= arr_rd_en;
      rv2_reg <= rv1_reg;
    end
  end

  // Hand-off to the output clock: two slots alternate so a slot stays
  // still for two read periods while the link side picks it up.
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_tog_reg <= 1'b0;
    end else if (fire) begin
      rd_tog_reg <= !rd_tog_reg;
    end
  end

  // Slot data; written only on a hand-off.
  always_ff @(posedge clk) begin
    if (fire) begin
      slot_w0_reg[!rd_tog_reg] <= arr_word0;
      slot_w1_reg[!rd_tog_reg] <= arr_word1;
    end
  end

  // PLL lock timer; restarts whenever the PLL is switched off.
  always_ff @(posedge clk) begin
    if (reset || !pll_on) begin
      lock_cnt_reg <= '0;
      pll_locked_reg <= 1'b0;
    end else if (lock_cnt_reg == `DPB_PLL_LOCK_W'(`DPB_PLL_LOCK_CYC - 1)) begin
      pll_locked_reg <= 1'b1;
    end else begin
      lock_cnt_reg <= lock_cnt_reg + 1'b1;
    end
  end

  // Impedance recalibration tick; the reference pin level is sampled at
  // each tick, so a change on it takes effect within one period.
  always_ff @(posedge clk) begin
    if (reset) begin
      zcal_cnt_reg <= '0;
      zcal_pulse_reg <= 1'b0;
      zstrong_reg <= 1'b0;
    end else begin
      zcal_cnt_reg <= zcal_cnt_reg + 1'b1;
      zcal_pulse_reg <= (zcal_cnt_reg == `DPB_ZCAL_W'(`DPB_ZCAL_CYC - 1));
      if (zcal_pulse_reg) begin
        zstrong_reg <= zref_s2_reg;
      end
    end
  end

  // Storage: bank 0 holds A+0 and bank 1 holds A+1 of each burst. The
  // write address is the one present at the strobe_n rise.
  dpb_array #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W)
  ) u_array (
    .clk(clk),
    .wr_en(arr_wr_en),
    .wr_addr(address),
    .wr_word0(wr_word0_reg),
    .wr_word1(write_data),
    .wr_lane0(wr_lane0_reg),
    .wr_lane1(wr_lane1),
    .rd_en(arr_rd_en),
    .rd_addr(rd_addr_reg),
    .rd_word0(arr_word0),
    .rd_word1(arr_word1)
  );

  // Output stage on the input clock, used in single-clock mode.
  dpb_outseq #(
    .DATA_W(DATA_W)
  ) u_core_seq (
    .clk(clk),
    .reset(reset),
    .start(fire && single_mode_reg),
    .word0(arr_word0),
    .word1(arr_word1),
    .q_reg(core_q),
    .oe_reg(core_oe)
  );

  // Link domain reset, brought in through two flops.
  always_ff @(posedge out_clk) begin
    lrst_s1_reg <= reset;
    lrst_s2_reg <= lrst_s1_reg;
  end

  // Burst toggle crossing; only the second and third flops are compared.
  always_ff @(posedge out_clk) begin
    if (lrst_s2_reg) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else begin
      tog_s1_reg <= rd_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  // Free-running echo on the output clock.
  always_ff @(posedge out_clk) begin
    if (lrst_s2_reg) begin
      echo_lnk_reg <= 1'b0;
    end else begin
      echo_lnk_reg <= !echo_lnk_reg;
    end
  end

  // Output stage on the output clock: word 0, word 1, then release. The
  // slot named by the synchronised toggle is stable while it is read.
  dpb_outseq #(
    .DATA_W(DATA_W)
  ) u_lnk_seq (
    .clk(out_clk),
    .reset(lrst_s2_reg),
    .start(lnk_ev),
    .word0(slot_w0_reg[tog_s2_reg]),
    .word1(slot_w1_reg[tog_s2_reg]),
    .q_reg(lnk_q),
    .oe_reg(lnk_oe)
  );

  // Pin selection by the strapped mode; the enable stays low until the
  // strap is taken, as the link side may not be reset yet.
  assign read_bus = single_mode_reg ? core_q : lnk_q;
  assign read_bus_oe = strap_done_reg && (single_mode_reg ? core_oe : lnk_oe);
  // Echo clocks follow the clock that times the output registers.
  assign echo_out_p = single_mode_reg ? phase_reg : echo_lnk_reg;
  assign echo_out_n = !echo_out_p;
  assign single_clock_mode = single_mode_reg;
  assign pll_locked = pll_locked_reg;
  assign impedance_cal_pulse = zcal_pulse_reg;
  assign impedance_strong = zstrong_reg;

endmodule
`default_nettype wire

// file: dpb_defines.svh
// Purpose: Shared constants of the dual-port burst SRAM block.
// Assumes: Included by its bare name from every design module file.
// Notes: Times are kept in their own unit and turned into cycles here.
`ifndef DPB_DEFINES_SVH
`define DPB_DEFINES_SVH

// Data word width of the narrow build and the width of one byte lane.
`define DPB_DATA_W 18
`define DPB_LANE_W 9

// Burst address widths that keep the same capacity for both builds.
`define DPB_ADDR_W_X18 19
`define DPB_ADDR_W_X36 18

// Core clock rate in MHz (each clk edge stands for one rising strobe edge, in_strobe_p or in_strobe_n).
`define DPB_CLK_MHZ 125

// PLL lock time in microseconds and its cycle count at the core rate.
`define DPB_PLL_LOCK_US 20
`define DPB_PLL_LOCK_CYC (`DPB_PLL_LOCK_US * `DPB_CLK_MHZ)
`define DPB_PLL_LOCK_W 12

// Impedance recalibration period in cycles and its counter width.
`define DPB_ZCAL_CYC 1024
`define DPB_ZCAL_W 10

// Reset values: ports deselected, read bus released.
`define DPB_SEL_RST 1'b0
`define DPB_OE_RST 1'b0
`define DPB_PHASE_RST 1'b0

`endif

// file: dpb_pkg.sv
// Purpose: Types shared by the dual-port burst SRAM block.
// Assumes: Nothing beyond a SystemVerilog compiler.
// Notes: Constants live in dpb_defines.svh; this holds types only.
package dpb_pkg;

  // States of the read burst output sequencer, one-hot.
  typedef enum logic [2:0] {
    DPB_SEQ_IDLE = 3'h1,
    DPB_SEQ_W0 = 3'h2,
    DPB_SEQ_W1 = 3'h4
  } dpb_seq_t;

endpackage

// file: dpb_array.sv
// Purpose: Two storage banks holding the two words of every burst.
// Assumes: Writes and reads are strobed on the same clock.
// Notes: Each byte lane of each bank is its own memory for lane writes.
`timescale 1ns/1ns
`default_nettype none
`include "dpb_defines.svh"

module dpb_array #(
  parameter int DATA_W = `DPB_DATA_W,
  parameter int ADDR_W = `DPB_ADDR_W_X18,
  localparam int LANES = DATA_W / `DPB_LANE_W
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_word0,
  input wire logic [DATA_W-1:0] wr_word1,
  input wire logic [LANES-1:0] wr_lane0,
  input wire logic [LANES-1:0] wr_lane1,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_word0,
  output logic [DATA_W-1:0] rd_word1
);

  genvar g;

  // One lane slice of both banks; bank 0 holds A+0, bank 1 holds A+1.
  for (g = 0; g < LANES; g++) begin : g_lane
    logic [`DPB_LANE_W-1:0] bank0_mem [0:(1<<ADDR_W)-1];
    logic [`DPB_LANE_W-1:0] bank1_mem [0:(1<<ADDR_W)-1];

    // A lane whose enable is low keeps its old contents.
    always_ff @(posedge clk) begin
      if (wr_en && wr_lane0[g]) begin
        bank0_mem[wr_addr] <= wr_word0[g*`DPB_LANE_W +: `DPB_LANE_W];
      end
      if (wr_en && wr_lane1[g]) begin
        bank1_mem[wr_addr] <= wr_word1[g*`DPB_LANE_W +: `DPB_LANE_W];
      end
    end

    // Registered read; holds its value between reads.
    always_ff @(posedge clk) begin
      if (rd_en) begin
        rd_word0[g*`DPB_LANE_W +: `DPB_LANE_W] <= bank0_mem[rd_addr];
        rd_word1[g*`DPB_LANE_W +: `DPB_LANE_W] <= bank1_mem[rd_addr];
      end
    end
  end

endmodule
`default_nettype wire

// file: dpb_outseq.sv
// Purpose: Drives the two words of one read burst, then releases the bus.
// Assumes: Start pulses are at least two clocks apart.
// Notes: Used once per output clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "dpb_defines.svh"

module dpb_outseq #(
  parameter int DATA_W = `DPB_DATA_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [DATA_W-1:0] word0,
  input wire logic [DATA_W-1:0] word1,
  output logic [DATA_W-1:0] q_reg,
  output logic oe_reg
);

  dpb_pkg::dpb_seq_t state_reg;
  dpb_pkg::dpb_seq_t state_next;
  logic [DATA_W-1:0] word1_reg;   // Second word, held for the next edge.
  logic [DATA_W-1:0] q_next;
  logic take;                     // A new burst may start this edge.

  assign take = start && (state_reg != dpb_pkg::DPB_SEQ_W0);

  // Next state and data; the bus is released one edge after word 1.
  always_comb begin
    state_next = dpb_pkg::DPB_SEQ_IDLE;
    q_next = q_reg;
    unique case (state_reg)
      dpb_pkg::DPB_SEQ_IDLE,
      dpb_pkg::DPB_SEQ_W1: begin
        if (take) begin
          state_next = dpb_pkg::DPB_SEQ_W0;
          q_next = word0;
        end
      end
      dpb_pkg::DPB_SEQ_W0: begin
        state_next = dpb_pkg::DPB_SEQ_W1;
        q_next = word1_reg;
      end
      default: state_next = dpb_pkg::DPB_SEQ_IDLE;
    endcase
  end

  // Output registers; the bus comes up released.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= dpb_pkg::DPB_SEQ_IDLE;
      oe_reg <= `DPB_OE_RST;
      q_reg <= '0;
    end else begin
      state_reg <= state_next;
      oe_reg <= (state_next != dpb_pkg::DPB_SEQ_IDLE);
      q_reg <= q_next;
    end
  end

  // The second word is captured with the start so the source may move on.
  always_ff @(posedge clk) begin
    if (take) begin
      word1_reg <= word1;
    end
  end

endmodule
`default_nettype wire

// file: dpb_sram_props.sv
// Purpose: Port-level checks of the dual-port burst SRAM.
// Assumes: Sees only top-level ports; all checks run on clk.
// Notes: Read timing checks are limited to single-clock mode.
`timescale 1ns/1ns
`default_nettype none

module dpb_sram_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic read_port_sel_n,
  input wire logic write_port_sel_n,
  input wire logic pll_disable_n,
  input wire logic read_bus_oe,
  input wire logic echo_out_p,
  input wire logic echo_out_n,
  input wire logic single_clock_mode,
  input wire logic pll_locked,
  input wire logic impedance_cal_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Cycles since the last calibration tick, and whether one was seen.
  logic [9:0] gap_reg;
  logic seen_reg;

  // The gap counter restarts at each tick, so it wraps exactly on time.
  always_ff @(posedge clk) begin
    if (reset) begin
      gap_reg <= 10'h000;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= impedance_cal_pulse ? 10'h000 : gap_reg + 10'h001;
      seen_reg <= seen_reg | impedance_cal_pulse;
    end
  end

  oe_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    reset |=> !read_bus_oe && !pll_locked)
    else $error("read bus or lock flag active after reset");
  oe_cause_a: assert property (single_clock_mode && $rose(read_bus_oe)
    |-> !$past(read_port_sel_n, 4) || !$past(read_port_sel_n, 5))
    else $error("read bus driven without a read at the right latency");
  oe_len_a: assert property (single_clock_mode && $rose(read_bus_oe)
    |-> ##1 read_bus_oe ##1 !read_bus_oe)
    else $error("read burst not two words then released");
  echo_pair_a: assert property (echo_out_n == !echo_out_p)
    else $error("echo clocks not complementary");
  echo_single_a: assert property (single_clock_mode
    && $past(single_clock_mode) |-> echo_out_p != $past(echo_out_p))
    else $error("echo clock not following input clock");
  strap_fixed_a: assert property (!$past(reset) && !$past(reset, 2)
    |-> $stable(single_clock_mode))
    else $error("clock mode changed during operation");
  pll_lock_a: assert property ($rose(pll_locked)
    |-> $past(pll_disable_n, 8))
    else $error("lock reported with the pll off");
  cal_gap_a: assert property (seen_reg && gap_reg != 10'h3ff
    |-> !impedance_cal_pulse)
    else $error("calibration tick too early");
  cal_due_a: assert property (seen_reg && gap_reg == 10'h3ff
    |-> impedance_cal_pulse)
    else $error("calibration tick missing");

  cover property ($rose(read_bus_oe));
  cover property ($rose(pll_locked));
  cover property (impedance_cal_pulse && seen_reg);
  cover property (!read_port_sel_n && !write_port_sel_n);
endmodule

bind dpb_sram dpb_sram_props u_props (
  .clk(clk),
  .reset(reset),
  .read_port_sel_n(read_port_sel_n),
  .write_port_sel_n(write_port_sel_n),
  .pll_disable_n(pll_disable_n),
  .read_bus_oe(read_bus_oe),
  .echo_out_p(echo_out_p),
  .echo_out_n(echo_out_n),
  .single_clock_mode(single_clock_mode),
  .pll_locked(pll_locked),
  .impedance_cal_pulse(impedance_cal_pulse)
);
`default_nettype wire

// file: dpb_ctrl_model.sv
// Purpose: Controller side: output clock source and read data capture.
// Assumes: The output clock runs free, as the echo clocks do.
// Notes: Words are captured on the output clock only.
`timescale 1ns/1ns
`default_nettype none

module dpb_ctrl_model (
  output logic out_clk,
  input wire logic read_bus_oe,
  input wire logic [17:0] read_bus
);
  // Captured read words, cleared by the bench before a burst.
  logic [17:0] cap[$];

  // A 6 ns output clock with an odd offset keeps it out of phase.
  initial begin
    out_clk = 1'b0;
    #2;
    forever #3 out_clk = ~out_clk;
  end

  // Read words are taken on the output clock while the bus is driven.
  always @(posedge out_clk) begin
    if (read_bus_oe === 1'b1) begin
      cap.push_back(read_bus);
    end
  end
endmodule
`default_nettype wire

// file: dual_port_ddr_burst_sram_tb.sv
// Purpose: Self-checking bench for the dual-port burst SRAM.
// Assumes: Narrow build; inputs change 1 ns after the rising clock edge.
// Notes: Even edge counts since reset mark the strobe_p edges.
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t value %h expected %h", $time, a, b); end end

module dual_port_ddr_burst_sram_tb;
  localparam logic [18:0] A = 19'h0_000a;
  localparam logic [17:0] D0 = 18'h1_2345;
  localparam logic [17:0] D1 = 18'h2_6789;
  localparam logic [17:0] N0 = 18'h0_abcd;
  localparam logic [17:0] N1 = 18'h3_1357;
  localparam logic [17:0] B0 = {N0[17:9], 9'h1ff};
  logic clk, reset, out_clk, read_port_sel_n, write_port_sel_n;
  logic [1:0] byte_lane_sel_n;
  logic [18:0] address;
  logic [17:0] write_data, read_bus;
  logic pll_disable_n, out_strobe_p, out_strobe_n, impedance_ref_pin;
  logic read_bus_oe, echo_out_p, echo_out_n, single_clock_mode;
  logic pll_locked, impedance_cal_pulse, impedance_strong;
  logic [15:0] ec;
  int errors = 0, comparisons = 0, tcnt = 0, t0;

  dpb_sram u_dut (.clk(clk), .reset(reset), .out_clk(out_clk),
    .read_port_sel_n(read_port_sel_n), .write_port_sel_n(write_port_sel_n),
    .byte_lane_sel_n(byte_lane_sel_n), .address(address),
    .write_data(write_data), .pll_disable_n(pll_disable_n),
    .out_strobe_p(out_strobe_p), .out_strobe_n(out_strobe_n),
    .impedance_ref_pin(impedance_ref_pin), .read_bus(read_bus),
    .read_bus_oe(read_bus_oe), .echo_out_p(echo_out_p),
    .echo_out_n(echo_out_n), .single_clock_mode(single_clock_mode),
    .pll_locked(pll_locked), .impedance_cal_pulse(impedance_cal_pulse),
    .impedance_strong(impedance_strong));
  dpb_ctrl_model u_ctrl (.out_clk(out_clk), .read_bus_oe(read_bus_oe),
    .read_bus(read_bus));

  // A 125 MHz input clock, above the lowest rate the pll accepts.
  // It never stops, so the optional clock-stop pll reset is unused.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Edge count since reset; requests may start only on even counts.
  always @(posedge clk) ec <= reset ? 16'h0000 : ec + 16'h0001;

  // Cuts a hang short; the run needs a little over 2500 cycles.
  always @(posedge clk) begin
    tcnt++;
    if (tcnt == 8000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // One access: word0 and selects on strobe_p, address and word1 after.
  // A lat of zero skips the bus checks (output clock mode).
  task automatic op(input logic rd, input logic wr, input logic [18:0] ra,
      input logic [18:0] wa, input logic [17:0] w0, input logic [17:0] w1,
      input logic [1:0] l0, input logic [1:0] l1, input logic [17:0] e0,
      input logic [17:0] e1, input int lat);
    while (ec[0]) step();
    read_port_sel_n = !rd;
    write_port_sel_n = !wr;
    address = rd ? ra : wa;
    write_data = w0;
    byte_lane_sel_n = l0;
    step();
    read_port_sel_n = 1'b1;
    write_port_sel_n = 1'b1;
    address = wa;
    write_data = w1;
    byte_lane_sel_n = l1;
    step();
    address = ~wa;
    write_data = ~w1;
    if (rd && lat > 0) begin
      repeat (lat - 1) step();
      `CHK(read_bus_oe, 1'b1)
      `CHK(read_bus, e0)
      step();
      `CHK(read_bus, e1)
      step();
      `CHK(read_bus_oe, 1'b0)
    end
  endtask

  task automatic do_reset(input logic strap);
    reset = 1'b1;
    out_strobe_p = strap;
    out_strobe_n = strap;
    repeat (2) step();
    reset = 1'b0;
    step();
  endtask

  initial begin
    {read_port_sel_n, write_port_sel_n, byte_lane_sel_n} = 4'hf;
    address = 19'h0_0000;
    write_data = 18'h0_0000;
    pll_disable_n = 1'b0;
    impedance_ref_pin = 1'b1;
    do_reset(1'b1);
    `CHK(single_clock_mode, 1'b1)
    `CHK(read_bus_oe, 1'b0)
    op(1'b0, 1'b1, A, A, D0, D1, 2'b00, 2'b00, D0, D1, 3);
    op(1'b1, 1'b0, A, A, D0, D1, 2'b00, 2'b00, D0, D1, 3);
    op(1'b1, 1'b1, A, A, N0, N1, 2'b00, 2'b00, N0, N1, 3);
    op(1'b0, 1'b1, A, A, 18'h3_ffff, 18'h3_ffff, 2'b10, 2'b11, 0, 0, 3);
    op(1'b1, 1'b0, A, A, 0, 0, 2'b11, 2'b11, B0, N1, 3);
    // A write select seen only on a strobe_n edge must be ignored.
    while (ec[0]) step();
    step();
    write_port_sel_n = 1'b0;
    byte_lane_sel_n = 2'b00;
    address = A;
    step();
    write_port_sel_n = 1'b1;
    step();
    op(1'b1, 1'b0, A, A, 0, 0, 2'b11, 2'b11, B0, N1, 3);
    pll_disable_n = 1'b1;
    t0 = ec;
    repeat (4) step();
    op(1'b1, 1'b0, A, A, 0, 0, 2'b11, 2'b11, B0, N1, 4);
    while (pll_locked !== 1'b1 && ec < t0 + 3000) step();
    `CHK(ec - t0 >= 2490 && ec - t0 <= 2510, 1'b1)
    `CHK(impedance_strong, 1'b1)
    do_reset(1'b0);
    `CHK(single_clock_mode, 1'b0)
    repeat (8) step();
    u_ctrl.cap.delete();
    op(1'b1, 1'b0, A, A, 0, 0, 2'b11, 2'b11, B0, N1, 0);
    repeat (12) step();
    `CHK(u_ctrl.cap.size(), 2)
    `CHK(u_ctrl.cap[0], B0)
    `CHK(u_ctrl.cap[1], N1)
    print_verdict();
  end
endmodule
`default_nettype wire
